// file: include/uart_rx_cfg.svh
// Register map, field positions, reset values and line timing for the serial receiver
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH

`define REG_TX_CTRL   3'h0
`define REG_RX_CTRL   3'h1
`define REG_BAUD_CTRL 3'h2
`define REG_DIV_LO    3'h3
`define REG_DIV_HI    3'h4
`define REG_RX_DATA   3'h5
`define REG_IRQ_CTRL  3'h6

`define TX_CLOCK_SOURCE_SELECT  7
`define TX_SYNC  4
`define TX_HIGH  2
`define TX_SHIFT_REG_EMPTY_FLAG  1
`define RC_SERIAL_PORT_ENABLE  7
`define RC_NINE  6
`define RC_SINGLE_RECEIVE_ENABLE  5
`define RC_CONTINUOUS_RECEIVE_ENABLE  4
`define RC_ADDR_DETECT_ENABLE 3
`define RC_FRAMING_ERROR_FLAG  2
`define RC_OVERRUN_FLAG  1
`define RC_D9    0
`define BD_ABOVF 7
`define BD_IDLE  6
`define BD_CLOCK_DATA_POLARITY_SELECT  4
`define BD_WIDE  3
`define BD_AUTOBAUD_ENABLE 0
`define IRQ_EN   0
`define IRQ_FLAG 1

`define TX_WMASK 8'hF5
`define RC_WMASK 8'hF8
`define BD_WMASK 8'h1B
`define TX_RESET 8'h00
`define RC_RESET 8'h00
`define BD_RESET 8'h00

`define PRE_SLOW   2'h3
`define PRE_FAST   2'h0
`define PRE_SYNC   2'h1
`define SMP_END    4'hF
`define SMP_MID    4'h7
`define SMP_END_Q  4'h3
`define SMP_MID_Q  4'h1
`define SMP_SPAN   4'h2
`define AB_SH_SLOW 3'h7
`define AB_SH_FAST 3'h5
`define AB_FALLS   3'h3
`define BITS_8     4'h7
`define BITS_9     4'h8

`endif

// file: include/uart_rx_pkg.sv
// Types shared by the serial receiver
`default_nettype none
package uart_rx_pkg;
  typedef logic [2:0] reg_index_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_SYNC} rx_state_t;
  typedef enum logic [1:0] {AB_IDLE, AB_WAIT, AB_COUNT} ab_state_t;
endpackage
`default_nettype wire

// file: core/uart_rx_address_detect_ctrl.sv
// Serial receiver with address detection, baud generator and Avalon-MM registers
`timescale 1ns/10ps
`default_nettype none
`include "uart_rx_cfg.svh"

module uart_rx_address_detect_ctrl (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire uart_rx_pkg::reg_index_t address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  output var  logic [31:0]             readdata,
  output var  logic                    waitrequest,
  input  wire logic                    rx_dt_in,
  output var  logic                    tx_ck_out,
  output var  logic                    tx_ck_oe_n,
  output var  logic                    receive_irq_request
);
  import uart_rx_pkg::*;

  logic        rst_meta;
  logic        rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Register state
  logic [7:0]  tx_ctrl, next_tx_ctrl;
  logic [7:0]  rx_ctrl, next_rx_ctrl;
  logic [7:0]  baud_ctrl, next_baud_ctrl;
  logic        autobaud_overflow_flag, next_autobaud_overflow_flag;
  logic [7:0]  divisor_low_byte, next_divisor_low_byte;
  logic [7:0]  divisor_high_byte, next_divisor_high_byte;
  logic        receive_irq_enable, next_receive_irq_enable;
  logic [8:0]  fifo_data [2];
  logic [8:0]  next_fifo_data [2];
  logic [1:0]  fifo_fe, next_fifo_fe;
  logic        fifo_head, next_fifo_head;
  logic [1:0]  fifo_count, next_fifo_count;
  logic        overrun_flag, next_overrun_flag;
  logic        pop_ok, next_pop_ok;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic        next_receive_irq_request;
  logic        next_tx_ck_out;
  logic        next_tx_ck_oe_n;

  // Line state
  logic [1:0]  brg_pre, next_brg_pre;
  logic [15:0] brg_cnt, next_brg_cnt;
  rx_state_t   rx_state, next_rx_state;
  logic [3:0]  smp_cnt, next_smp_cnt;
  logic [2:0]  maj, next_maj;
  logic [3:0]  bit_cnt, next_bit_cnt;
  logic [8:0]  receive_shift_reg, next_receive_shift_reg;
  logic        rx_prev, next_rx_prev;
  logic        ck_level, next_ck_level;
  ab_state_t   ab_state, next_ab_state;
  logic [2:0]  ab_falls, next_ab_falls;
  logic [23:0] ab_cnt, next_ab_cnt;
  logic        ab_load_q;

  // Cross-group events
  logic        tick, pre_evt, push, push_fe, single_receive_enable_done;
  logic        ab_load, ab_ovf, ab_finish, bit_val, fall;
  logic [8:0]  push_data;
  logic [15:0] ab_value;
  logic [23:0] ab_shifted;

  logic        serial_port_enable, sync_mode, wide_divisor_select, high_speed_select;
  logic        nine_bit_receive_select, addr_detect_enable, clock_data_polarity_select;
  logic        continuous_receive_enable, single_receive_enable, autobaud_enable;
  logic        quarter_mode, rx_enable, div_write, acc_read, acc_write;
  logic        receive_flag, receive_idle_flag;
  logic [1:0]  pre_lim;
  logic [3:0]  smp_end, smp_mid, bit_last;
  logic [15:0] divisor;

  assign serial_port_enable         = rx_ctrl[`RC_SERIAL_PORT_ENABLE];
  assign nine_bit_receive_select    = rx_ctrl[`RC_NINE];
  assign single_receive_enable      = rx_ctrl[`RC_SINGLE_RECEIVE_ENABLE];
  assign continuous_receive_enable  = rx_ctrl[`RC_CONTINUOUS_RECEIVE_ENABLE];
  assign addr_detect_enable         = rx_ctrl[`RC_ADDR_DETECT_ENABLE];
  assign sync_mode                  = tx_ctrl[`TX_SYNC];
  assign high_speed_select          = tx_ctrl[`TX_HIGH];
  assign wide_divisor_select        = baud_ctrl[`BD_WIDE];
  assign clock_data_polarity_select = baud_ctrl[`BD_CLOCK_DATA_POLARITY_SELECT];
  assign autobaud_enable            = baud_ctrl[`BD_AUTOBAUD_ENABLE];
  assign acc_read  = read && !waitrequest;
  assign acc_write = write && !waitrequest;
  assign div_write = acc_write && (address == `REG_DIV_LO || address == `REG_DIV_HI);

  // Divide by 64, 16 or 4 times divisor plus one; the 4x mode samples 4 per bit
  assign quarter_mode = !sync_mode && wide_divisor_select && high_speed_select;
  assign pre_lim = sync_mode ? `PRE_SYNC :
                   (wide_divisor_select || high_speed_select) ? `PRE_FAST : `PRE_SLOW;
  assign divisor = wide_divisor_select ? {divisor_high_byte, divisor_low_byte}
                                       : {8'h00, divisor_low_byte};
  assign smp_end  = quarter_mode ? `SMP_END_Q : `SMP_END;
  assign smp_mid  = quarter_mode ? `SMP_MID_Q : `SMP_MID;
  assign bit_last = nine_bit_receive_select ? `BITS_9 : `BITS_8;
  assign rx_enable = serial_port_enable && !overrun_flag &&
                     (continuous_receive_enable || (sync_mode && single_receive_enable));
  assign fall = rx_prev && !rx_dt_in;
  assign ab_shifted = ab_cnt >> (quarter_mode ? `AB_SH_FAST : `AB_SH_SLOW);
  assign ab_value = ab_shifted[15:0] - 16'h0001;
  assign receive_flag = (fifo_count != 2'h0);
  assign receive_idle_flag = (rx_state == RX_IDLE);

  // Baud timer, receiver and auto-baud measurement
  always_comb begin
    next_brg_pre = brg_pre;
    next_brg_cnt = brg_cnt;
    next_rx_state = rx_state;
    next_smp_cnt = smp_cnt;
    next_maj = maj;
    next_bit_cnt = bit_cnt;
    next_receive_shift_reg = receive_shift_reg;
    next_rx_prev = rx_dt_in;
    next_ck_level = ck_level;
    next_ab_state = ab_state;
    next_ab_falls = ab_falls;
    next_ab_cnt = ab_cnt;
    tick = 1'b0;
    pre_evt = 1'b0;
    push = 1'b0;
    push_fe = 1'b0;
    push_data = receive_shift_reg;
    single_receive_enable_done = 1'b0;
    ab_load = 1'b0;
    ab_ovf = 1'b0;
    bit_val = 1'b0;
    // Restart on divisor change; an auto-baud load restarts with the new divisor one clock later, a register write reloads the old divisor first
    if (div_write || ab_load_q || !serial_port_enable) begin
      next_brg_pre = pre_lim;
      next_brg_cnt = divisor;
    end else if (brg_pre != 2'h0) begin
      next_brg_pre = brg_pre - 2'h1;
    end else begin
      pre_evt = 1'b1;
      next_brg_pre = pre_lim;
      if (brg_cnt != 16'h0000) begin
        next_brg_cnt = brg_cnt - 16'h0001;
      end else begin
        tick = 1'b1;
        next_brg_cnt = divisor;
      end
    end
    if (tick && smp_cnt >= smp_mid && smp_cnt <= smp_mid + `SMP_SPAN) begin
      next_maj = {maj[1:0], rx_dt_in};
    end
    bit_val = (next_maj[0] & next_maj[1]) | (next_maj[0] & next_maj[2]) |
              (next_maj[1] & next_maj[2]);
    case (rx_state)
      RX_IDLE: begin
        if (rx_enable && ab_state == AB_IDLE) begin
          if (sync_mode) begin
            if (tx_ctrl[`TX_CLOCK_SOURCE_SELECT]) begin
              next_rx_state = RX_SYNC;
              next_bit_cnt = 4'h0;
              next_ck_level = clock_data_polarity_select;
            end
          end else if (fall) begin
            next_rx_state = RX_START;
            next_smp_cnt = 4'h0;
          end
        end
      end
      RX_START: begin
        if (tick) begin
          next_smp_cnt = smp_cnt + 4'h1;
          // A glitch that is high again at mid-bit is dropped without error
          if (smp_cnt == smp_mid && rx_dt_in) begin
            next_rx_state = RX_IDLE;
          end else if (smp_cnt == smp_end) begin
            next_rx_state = RX_DATA;
            next_smp_cnt = 4'h0;
            next_bit_cnt = 4'h0;
          end
        end
      end
      RX_DATA, RX_STOP: begin
        if (tick) begin
          next_smp_cnt = smp_cnt + 4'h1;
          if (smp_cnt == smp_end) begin
            next_smp_cnt = 4'h0;
            if (rx_state == RX_DATA) begin
              next_receive_shift_reg = {bit_val, receive_shift_reg[8:1]};
              next_bit_cnt = bit_cnt + 4'h1;
              if (bit_cnt == bit_last) begin
                next_rx_state = RX_STOP;
              end
            end else begin
              next_rx_state = RX_IDLE;
              push_fe = !bit_val;
              push_data = nine_bit_receive_select ? receive_shift_reg
                                                  : {1'b0, receive_shift_reg[8:1]};
              // Non-address characters vanish while address detect and nine-bit receive are both on
              push = !(addr_detect_enable && nine_bit_receive_select &&
                       !receive_shift_reg[8]);
            end
          end
        end
      end
      RX_SYNC: begin
        if (tick) begin
          next_ck_level = !ck_level;
          // Sample on the edge opposite the one on which data changes
          if (ck_level == clock_data_polarity_select) begin
            next_receive_shift_reg = {rx_dt_in, receive_shift_reg[8:1]};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (bit_cnt == bit_last + 4'h1) begin
            next_rx_state = RX_IDLE;
            push = 1'b1;
            push_data = nine_bit_receive_select ? receive_shift_reg
                                                : {1'b0, receive_shift_reg[8:1]};
            single_receive_enable_done = !continuous_receive_enable;
          end
        end
      end
      default: next_rx_state = RX_IDLE;
    endcase
    if (!rx_enable && rx_state != RX_IDLE) begin
      next_rx_state = RX_IDLE;
      next_ck_level = clock_data_polarity_select;
    end
    case (ab_state)
      AB_IDLE: begin
        if (autobaud_enable && serial_port_enable && !sync_mode) begin
          next_ab_state = AB_WAIT;
        end
      end
      AB_WAIT: begin
        if (fall) begin
          next_ab_state = AB_COUNT;
          next_ab_cnt = 24'h000000;
          next_ab_falls = 3'h0;
        end
      end
      AB_COUNT: begin
        if (pre_evt) begin
          next_ab_cnt = ab_cnt + 24'h000001;
        end
        if (ab_cnt == 24'hFFFFFF) begin
          ab_ovf = 1'b1;
          next_ab_state = AB_IDLE;
        end else if (fall) begin
          next_ab_falls = ab_falls + 3'h1;
          // Four more falling edges of the 0x55 pattern span eight bits
          if (ab_falls == `AB_FALLS) begin
            ab_load = 1'b1;
            next_ab_state = AB_IDLE;
          end
        end
      end
      default: next_ab_state = AB_IDLE;
    endcase
    if (!autobaud_enable || !serial_port_enable) begin
      next_ab_state = AB_IDLE;
    end
    ab_finish = ab_load || ab_ovf;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_load_q <= 1'b0;
      brg_pre <= 2'h0;
      brg_cnt <= 16'h0000;
      rx_state <= RX_IDLE;
      smp_cnt <= 4'h0;
      maj <= 3'h7;
      bit_cnt <= 4'h0;
      receive_shift_reg <= 9'h000;
      rx_prev <= 1'b1;
      ck_level <= 1'b0;
      ab_state <= AB_IDLE;
      ab_falls <= 3'h0;
      ab_cnt <= 24'h000000;
    end else begin
      ab_load_q <= ab_load;
      brg_pre <= next_brg_pre;
      brg_cnt <= next_brg_cnt;
      rx_state <= next_rx_state;
      smp_cnt <= next_smp_cnt;
      maj <= next_maj;
      bit_cnt <= next_bit_cnt;
      receive_shift_reg <= next_receive_shift_reg;
      rx_prev <= next_rx_prev;
      ck_level <= next_ck_level;
      ab_state <= next_ab_state;
      ab_falls <= next_ab_falls;
      ab_cnt <= next_ab_cnt;
    end
  end

  // Register file, receive buffer and pins
  always_comb begin
    logic       wr_idx;
    logic       top_fe;
    logic [8:0] top;
    wr_idx = fifo_head ^ fifo_count[0];
    top = receive_flag ? fifo_data[fifo_head] : 9'h000;
    top_fe = receive_flag && fifo_fe[fifo_head];
    next_tx_ctrl = tx_ctrl;
    next_rx_ctrl = rx_ctrl;
    next_baud_ctrl = baud_ctrl;
    next_autobaud_overflow_flag = autobaud_overflow_flag;
    next_divisor_low_byte = divisor_low_byte;
    next_divisor_high_byte = divisor_high_byte;
    next_receive_irq_enable = receive_irq_enable;
    next_fifo_data = fifo_data;
    next_fifo_fe = fifo_fe;
    next_fifo_head = fifo_head;
    next_fifo_count = fifo_count;
    next_overrun_flag = overrun_flag;
    next_pop_ok = pop_ok;
    next_readdata = readdata;
    next_waitrequest = !((read || write) && waitrequest);
    if (read && waitrequest) begin
      next_pop_ok = receive_flag;
      next_readdata = 32'h00000000;
      case (address)
        `REG_TX_CTRL:   next_readdata[7:0] = tx_ctrl | (8'h01 << `TX_SHIFT_REG_EMPTY_FLAG);
        `REG_RX_CTRL:   next_readdata[7:0] = {rx_ctrl[7:3], top_fe, overrun_flag, top[8]};
        `REG_BAUD_CTRL: next_readdata[7:0] = baud_ctrl |
                          ({7'h00, autobaud_overflow_flag} << `BD_ABOVF) |
                          ({7'h00, receive_idle_flag} << `BD_IDLE);
        `REG_DIV_LO:    next_readdata[7:0] = divisor_low_byte;
        `REG_DIV_HI:    next_readdata[7:0] = divisor_high_byte;
        `REG_RX_DATA:   next_readdata[7:0] = top[7:0];
        `REG_IRQ_CTRL:  next_readdata[7:0] = ({7'h00, receive_flag} << `IRQ_FLAG) |
                          ({7'h00, receive_irq_enable} << `IRQ_EN);
        default:        next_readdata = 32'h00000000;
      endcase
    end
    if (acc_read && address == `REG_RX_DATA && pop_ok) begin
      next_fifo_head = !fifo_head;
      next_fifo_count = fifo_count - 2'h1;
    end
    if (acc_write) begin
      case (address)
        `REG_TX_CTRL:   next_tx_ctrl = writedata[7:0] & `TX_WMASK;
        `REG_RX_CTRL:   next_rx_ctrl = writedata[7:0] & `RC_WMASK;
        `REG_BAUD_CTRL: begin
          next_baud_ctrl = writedata[7:0] & `BD_WMASK;
          if (writedata[`BD_AUTOBAUD_ENABLE]) begin
            next_autobaud_overflow_flag = 1'b0;
          end
        end
        `REG_DIV_LO:    next_divisor_low_byte = writedata[7:0];
        `REG_DIV_HI:    next_divisor_high_byte = writedata[7:0];
        `REG_IRQ_CTRL:  next_receive_irq_enable = writedata[`IRQ_EN];
        default:        next_receive_irq_enable = receive_irq_enable;
      endcase
    end
    if (single_receive_enable_done) begin
      next_rx_ctrl[`RC_SINGLE_RECEIVE_ENABLE] = 1'b0;
    end
    if (ab_load) begin
      next_divisor_low_byte = ab_value[7:0];
      next_divisor_high_byte = ab_value[15:8];
    end
    if (ab_ovf) begin
      next_autobaud_overflow_flag = 1'b1;
    end
    if (ab_finish) begin
      next_baud_ctrl[`BD_AUTOBAUD_ENABLE] = 1'b0;
    end
    if (!next_rx_ctrl[`RC_CONTINUOUS_RECEIVE_ENABLE]) begin
      next_overrun_flag = 1'b0;
    end
    if (push && !overrun_flag) begin
      if (fifo_count == 2'h2) begin
        next_overrun_flag = 1'b1;
      end else begin
        next_fifo_data[wr_idx] = push_data;
        next_fifo_fe[wr_idx] = push_fe;
        next_fifo_count = next_fifo_count + 2'h1;
      end
    end
    // Port disable empties the buffer and forces the error flags clear
    if (!serial_port_enable) begin
      next_fifo_count = 2'h0;
      next_fifo_head = 1'b0;
      next_overrun_flag = 1'b0;
    end
    next_receive_irq_request = (next_fifo_count != 2'h0) && next_receive_irq_enable;
    next_tx_ck_oe_n = !(serial_port_enable && !(sync_mode && !tx_ctrl[`TX_CLOCK_SOURCE_SELECT]));
    // Released pin rests high, also as a sync slave
    if (next_tx_ck_oe_n) begin
      next_tx_ck_out = 1'b1;
    end else if (sync_mode) begin
      next_tx_ck_out = ck_level;
    end else begin
      next_tx_ck_out = !clock_data_polarity_select;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ctrl <= `TX_RESET;
      rx_ctrl <= `RC_RESET;
      baud_ctrl <= `BD_RESET;
      autobaud_overflow_flag <= 1'b0;
      divisor_low_byte <= 8'h00;
      divisor_high_byte <= 8'h00;
      receive_irq_enable <= 1'b0;
      fifo_data[0] <= 9'h000;
      fifo_data[1] <= 9'h000;
      fifo_fe <= 2'h0;
      fifo_head <= 1'b0;
      fifo_count <= 2'h0;
      overrun_flag <= 1'b0;
      pop_ok <= 1'b0;
      readdata <= 32'h00000000;
      waitrequest <= 1'b1;
      receive_irq_request <= 1'b0;
      tx_ck_out <= 1'b1;
      tx_ck_oe_n <= 1'b1;
    end else begin
      tx_ctrl <= next_tx_ctrl;
      rx_ctrl <= next_rx_ctrl;
      baud_ctrl <= next_baud_ctrl;
      autobaud_overflow_flag <= next_autobaud_overflow_flag;
      divisor_low_byte <= next_divisor_low_byte;
      divisor_high_byte <= next_divisor_high_byte;
      receive_irq_enable <= next_receive_irq_enable;
      fifo_data <= next_fifo_data;
      fifo_fe <= next_fifo_fe;
      fifo_head <= next_fifo_head;
      fifo_count <= next_fifo_count;
      overrun_flag <= next_overrun_flag;
      pop_ok <= next_pop_ok;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      receive_irq_request <= next_receive_irq_request;
      tx_ck_out <= next_tx_ck_out;
      tx_ck_oe_n <= next_tx_ck_oe_n;
    end
  end

endmodule // uart_rx_address_detect_ctrl
`default_nettype wire

// file: verification/uart_rx_address_detect_ctrl_assertions.sv
// Port-level checks for the serial receiver
`timescale 1ns/10ps
`default_nettype none
module uart_rx_checks (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire uart_rx_pkg::reg_index_t address,
  input wire logic                    read,
  input wire logic                    write,
  input wire logic [31:0]             writedata,
  input wire logic [31:0]             readdata,
  input wire logic                    waitrequest,
  input wire logic                    rx_dt_in,
  input wire logic                    tx_ck_out,
  input wire logic                    tx_ck_oe_n,
  input wire logic                    receive_irq_request
);
  import uart_rx_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_needs_req: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without a request");
  a_req_answered: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered next cycle");
  a_rd_upper_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (
      read && address == 3'h7 && waitrequest |=> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_rd_hold: assert property ($changed(readdata) |-> !waitrequest && $past(read))
    else $error("read data changed outside a read");
  a_irq_fall: assert property ($fell(receive_irq_request) |->
      $past(!waitrequest) || $past(!waitrequest, 2) || $past(!waitrequest, 3))
    else $error("interrupt dropped without a register access");
  a_idle_high: assert property (tx_ck_oe_n |-> tx_ck_out)
    else $error("undriven pin level not high");
endmodule // uart_rx_checks
bind uart_rx_address_detect_ctrl uart_rx_checks u_uart_rx_checks (.clk(clk), .reset_n(reset_n),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .rx_dt_in(rx_dt_in), .tx_ck_out(tx_ck_out),
  .tx_ck_oe_n(tx_ck_oe_n), .receive_irq_request(receive_irq_request));
`default_nettype wire

// file: verification/remote_serial_node.sv
// Remote node on the shared line, sending nine-bit characters
`timescale 1ns/10ps
`default_nettype none
module remote_serial_node #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic clk,
  output var  logic line
);
  initial line = 1'b1;
  // Bad stop level models a framing fault on the line
  task automatic send(input logic [8:0] v, input logic stop_ok);
    logic [10:0] frame;
    frame = {stop_ok, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= frame[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
endmodule // remote_serial_node
`default_nettype wire

// file: verification/uart_rx_address_detect_ctrl_tb.sv
// Self-checking bench for the serial receiver
`timescale 1ns/10ps
`default_nettype none
module uart_rx_address_detect_ctrl_tb;
  import uart_rx_pkg::*;
  logic        clk, reset_n, read, write, rx_dt_in, waitrequest;
  logic        tx_ck_out, tx_ck_oe_n, receive_irq_request, ovr, en;
  reg_index_t  address;
  logic [31:0] writedata, readdata, r;
  logic [7:0]  ctl;
  logic [9:0]  q[$];
  int          failures, comparisons;
  integer      seed;
  uart_rx_address_detect_ctrl u_uart_rx_address_detect_ctrl (.clk(clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rx_dt_in(rx_dt_in), .tx_ck_out(tx_ck_out),
    .tx_ck_oe_n(tx_ck_oe_n), .receive_irq_request(receive_irq_request));
  remote_serial_node u_remote_serial_node (.clk(clk), .line(rx_dt_in));
  always #2 clk = ~clk;
  task automatic tally_and_finish;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input reg_index_t a, input logic [7:0] d);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        failures++;
        $display("mismatch at %0t: no bus answer", $time);
        tally_and_finish;
      end
      @(posedge clk);
    end
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic node_char(input logic [8:0] v, input logic ok);
    u_remote_serial_node.send(v, ok);
    if (!(ctl[3] && ctl[6] && !v[8])) begin
      if (ovr || q.size() == 2) ovr = 1'b1;
      else q.push_back({!ok, v});
    end
    chk(receive_irq_request, en && q.size() != 0);
  endtask
  task automatic drain;
    while (q.size() != 0) begin
      acc(1'b0, 3'h1, 8'h00);
      chk(r, {24'h0, ctl[7:3], q[0][9], ovr, q[0][8]});
      acc(1'b0, 3'h5, 8'h00);
      chk(r, {24'h0, q[0][7:0]});
      void'(q.pop_front());
    end
    repeat (3) @(posedge clk);
    chk(receive_irq_request, 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 3'h0;
    writedata = 32'h0;
    failures = 0;
    comparisons = 0;
    seed = 32'hd731;
    ovr = 1'b0;
    en = 1'b1;
    ctl = 8'h00;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1'b0, 3'h0, 8'h00);
    chk(r, 32'h2);
    acc(1'b0, 3'h1, 8'h00);
    chk(r, 32'h0);
    acc(1'b1, 3'h7, 8'hFF);
    acc(1'b0, 3'h7, 8'h00);
    chk(r, 32'h0);
    acc(1'b1, 3'h3, 8'h03);
    acc(1'b1, 3'h2, 8'h08);
    acc(1'b1, 3'h6, 8'h01);
    ctl = 8'hC0;
    acc(1'b1, 3'h1, ctl);
    // Pin registers follow the control write one edge later
    @(posedge clk);
    chk({tx_ck_oe_n, tx_ck_out}, 32'h1);
    ctl = 8'hC8;
    acc(1'b1, 3'h1, ctl);
    ctl = 8'hD8;
    acc(1'b1, 3'h1, ctl);
    for (int i = 0; i < 4; i++) node_char({i[0], 8'($random(seed))}, 1'b1);
    drain;
    ctl = 8'hD0;
    acc(1'b1, 3'h1, ctl);
    for (int i = 0; i < 4; i++) node_char(9'($random(seed)), i != 1);
    drain;
    ctl = 8'hC0;
    acc(1'b1, 3'h1, ctl);
    ovr = 1'b0;
    acc(1'b0, 3'h1, 8'h00);
    chk(r & 32'hFE, 32'hC0);
    ctl = 8'hD8;
    acc(1'b1, 3'h1, ctl);
    en = 1'b0;
    acc(1'b1, 3'h6, 8'h00);
    // Same 64-clock bit from the 8-bit divisor over 16, with the pin inverted
    acc(1'b1, 3'h0, 8'h04);
    acc(1'b1, 3'h2, 8'h10);
    acc(1'b0, 3'h0, 8'h00);
    chk(r, 32'h6);
    chk({tx_ck_oe_n, tx_ck_out}, 32'h0);
    node_char({1'b1, 8'($random(seed))}, 1'b1);
    acc(1'b0, 3'h6, 8'h00);
    chk(r, 32'h2);
    drain;
    tally_and_finish;
  end
  initial begin
    #400000;
    failures++;
    $display("mismatch at %0t: run too long", $time);
    tally_and_finish;
  end
endmodule // uart_rx_address_detect_ctrl_tb
`default_nettype wire
